// ===== bench/half_bridge_pwm_autorestart_bench.sv
// Self-checking bench for the half-bridge PWM output stage
`default_nettype none
module half_bridge_pwm_autorestart_bench
  import hbpwm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst_n, tick, raw, sd, fclr, wr, rd, rd_q, flag, shoot;
  logic [2:0]  addr;
  logic [7:0]  wd, rdata;
  logic [1:0]  tc;
  logic [6:0]  db;
  logic [7:0]  expq[$];
  hbpwm_pins_s pins;
  int          failures, cmp_count;
  hbpwm_core u_hbpwm_core (.clk_in(clk), .reset_n_in(rst_n),
    .inst_cycle_in(tick), .pwm_raw_in(raw), .shutdown_in(sd),
    .flag_clear_in(fclr), .addr_in(addr), .wdata_in(wd), .wr_in(wr),
    .rd_in(rd), .rdata_out(rdata), .pins_out(pins),
    .shutdown_event_flag_out(flag));
  hbpwm_load u_hbpwm_load (.clk_in(clk), .pins_in(pins), .shoot_out(shoot));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    tc <= tc + 2'h1;
    tick <= (tc == 2'h3);
    rd_q <= rd;
    if (rd_q) chk("rdata", expq.pop_front(), rdata);
    if (rst_n) chk("overlap", 8'h00, {7'h00, shoot});
  end
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic w(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr_t(logic [2:0] a, logic [7:0] d);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    w(1);
    wr <= 1'b0;
    w(1);
  endtask
  task automatic rd_t(logic [2:0] a, logic [7:0] e);
    expq.push_back(e);
    rd <= 1'b1;
    addr <= a;
    w(1);
    rd <= 1'b0;
    w(1);
  endtask
  task automatic pin(logic [1:0] e);
    chk("pins", {6'h00, e}, {6'h00, pins});
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    {rst_n, tick, raw, sd, fclr, wr, rd, rd_q, addr, wd, tc} = '0;
    failures = 0;
    cmp_count = 0;
    void'($urandom(80));
    w(4);
    rst_n <= 1'b1;
    rd_t(3'h0, CTRL_RESET);
    rd_t(3'h1, 8'h00);
    rd_t(3'h5, 8'h00);
    $display("reset and map test done");
    db = 7'($urandom_range(1, 3));
    wr_t(3'h0, {1'b1, db});
    rd_t(3'h0, {1'b1, db});
    raw <= 1'b1;
    w(40);
    pin(2'b10);
    raw <= 1'b0;
    w(40);
    pin(2'b01);
    wr_t(3'h0, 8'h7f);
    raw <= 1'b1;
    w(8);
    pin(2'b00);
    raw <= 1'b0;
    wr_t(3'h0, 8'h81);
    raw <= 1'b1;
    w(40);
    pin(2'b10);
    $display("dead-band test done");
    sd <= 1'b1;
    w(10);
    chk("flag", 8'h01, {7'h00, flag});
    pin(2'b00);
    rd_t(3'h1, 8'h03);
    sd <= 1'b0;
    w(10);
    chk("flag", 8'h00, {7'h00, flag});
    w(40);
    pin(2'b10);
    wr_t(3'h0, 8'h01);
    sd <= 1'b1;
    w(10);
    sd <= 1'b0;
    w(40);
    chk("flag", 8'h01, {7'h00, flag});
    pin(2'b00);
    rd_t(3'h1, 8'h01);
    fclr <= 1'b1;
    w(1);
    fclr <= 1'b0;
    w(40);
    chk("flag", 8'h00, {7'h00, flag});
    pin(2'b10);
    sd <= 1'b1;
    w(10);
    sd <= 1'b0;
    w(40);
    chk("flag", 8'h01, {7'h00, flag});
    wr_t(3'h1, 8'h00);
    w(40);
    chk("flag", 8'h00, {7'h00, flag});
    pin(2'b10);
    $display("shutdown test done");
    end_of_test();
  end
  initial
  begin
    w(5000);
    failures++;
    end_of_test();
  end
endmodule
`default_nettype wire

// ===== bench/hbpwm_load.sv
// Model of the push-pull power switches on the two output pins
`default_nettype none
module hbpwm_load
  import hbpwm_pkg::*;
(
  input  wire logic        clk_in,
  input  wire hbpwm_pins_s pins_in,
  output logic             shoot_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Both switches on at once shorts the supply rail
  always_ff @(posedge clk_in)
  begin
    shoot_out <= pins_in.pwm_primary & pins_in.pwm_complement;
  end
endmodule
`default_nettype wire

// ===== logic/hbpwm_core.sv
// Half-bridge output stage with dead-band and auto-restart
//
// Our own choices: the plain strobed port and the register addresses.
`default_nettype none
module hbpwm_core
  import hbpwm_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        inst_cycle_in,
  input  wire logic        pwm_raw_in,
  input  wire logic        shutdown_in,
  input  wire logic        flag_clear_in,
  input  wire logic [2:0]  addr_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [7:0]  rdata_out,
  output var hbpwm_pins_s  pins_out,
  output logic             shutdown_event_flag_out
);
  localparam logic [2:0] ADDR_CTRL   = 3'h0;
  localparam logic [2:0] ADDR_STATUS = 3'h1;
  // Counter stops here so a long level cannot wrap back under the count
  localparam logic [6:0] DB_SATURATE = 7'h7f;

  //--------------------------------------------------------------
  // Shutdown input synchroniser
  //--------------------------------------------------------------
  logic [1:0] sd_sync_reg;
  logic [1:0] sd_sync_next;
  always_comb
  begin
    sd_sync_next = {sd_sync_reg[0], shutdown_in};
  end
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
      sd_sync_reg <= 2'h0;
    else
      sd_sync_reg <= sd_sync_next;
  end
  wire logic shutdown_active = sd_sync_reg[1];

  //--------------------------------------------------------------
  // Register port and shutdown flag
  //--------------------------------------------------------------
  logic [7:0] pwm_control_reg;
  logic [7:0] ctrl_next;
  logic       flag_reg;
  logic       flag_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  wire logic  restart_enable_bit = pwm_control_reg[RST_BIT];
  wire logic [6:0] deadband_cycle_count = pwm_control_reg[DB_MSB:0];

  always_comb
  begin
    ctrl_next  = pwm_control_reg;
    flag_next  = flag_reg;
    rdata_next = 8'h00;
    if (wr_in && addr_in == ADDR_CTRL)
      ctrl_next = wdata_in;
    if ((wr_in && addr_in == ADDR_STATUS && !wdata_in[0]) || flag_clear_in)
      flag_next = 1'b0;
    if (restart_enable_bit && !shutdown_active)
      flag_next = 1'b0;
    if (shutdown_active)
      flag_next = 1'b1;
    if (rd_in)
    begin
      case (addr_in)
        ADDR_CTRL:   rdata_next = pwm_control_reg;
        ADDR_STATUS: rdata_next = {6'h00, shutdown_active, flag_reg};
        default:     rdata_next = 8'h00;
      endcase
    end
  end
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      pwm_control_reg <= CTRL_RESET;
      flag_reg        <= 1'b0;
      rdata_reg       <= 8'h00;
    end
    else
    begin
      pwm_control_reg <= ctrl_next;
      flag_reg        <= flag_next;
      rdata_reg       <= rdata_next;
    end
  end

  //--------------------------------------------------------------
  // Dead-band delay per output
  //--------------------------------------------------------------
  logic [6:0] cnt_a_reg;
  logic [6:0] cnt_b_reg;
  logic [6:0] cnt_a_next;
  logic [6:0] cnt_b_next;
  logic       out_a_reg;
  logic       out_b_reg;
  logic       out_a_next;
  logic       out_b_next;

  function automatic logic [6:0] db_step(input logic want,
                                         input logic [6:0] cnt,
                                         input logic tick);
    if (!want)
      db_step = DB_ZERO;
    else if (tick && cnt != DB_SATURATE)
      db_step = cnt + DB_ONE;
    else
      db_step = cnt;
  endfunction

  always_comb
  begin
    // Count inactive-to-active delay separately for each output
    cnt_a_next = db_step(pwm_raw_in, cnt_a_reg, inst_cycle_in);
    cnt_b_next = db_step(!pwm_raw_in, cnt_b_reg, inst_cycle_in);
    // If the level ends before the count, output never goes active
    out_a_next = pwm_raw_in && (cnt_a_reg >= deadband_cycle_count);
    out_b_next = !pwm_raw_in && (cnt_b_reg >= deadband_cycle_count);
    if (flag_reg || shutdown_active)
    begin
      out_a_next = 1'b0;
      out_b_next = 1'b0;
    end
  end
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      cnt_a_reg <= DB_ZERO;
      cnt_b_reg <= DB_ZERO;
      out_a_reg <= 1'b0;
      out_b_reg <= 1'b0;
    end
    else
    begin
      cnt_a_reg <= cnt_a_next;
      cnt_b_reg <= cnt_b_next;
      out_a_reg <= out_a_next;
      out_b_reg <= out_b_next;
    end
  end

  always_comb
  begin
    pins_out.pwm_primary    = out_a_reg;
    pins_out.pwm_complement = out_b_reg;
  end
  assign rdata_out               = rdata_reg;
  assign shutdown_event_flag_out = flag_reg;

  //--------------------------------------------------------------
  // Assertions: register port and flag
  //--------------------------------------------------------------
  a_ctrl_write: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (wr_in && addr_in == ADDR_CTRL) |=> pwm_control_reg == $past(wdata_in))
    else $error("control write lost");
  a_ctrl_read: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (rd_in && addr_in == ADDR_CTRL) |=> rdata_reg == $past(pwm_control_reg))
    else $error("control read wrong");
  a_rdata_idle: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !rd_in |=> rdata_reg == 8'h00) else $error("read data outside read");
  a_status_clear: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (wr_in && addr_in == ADDR_STATUS && !wdata_in[0] && !shutdown_active)
    |=> !flag_reg) else $error("status write did not clear flag");

  //--------------------------------------------------------------
  // Assertions: outputs, dead-band and flag
  //--------------------------------------------------------------
  a_sd_quiet: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    shutdown_active |=> !out_a_reg && !out_b_reg)
    else $error("output while shutdown active");
  a_cnt_a_clear: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !pwm_raw_in |=> cnt_a_reg == DB_ZERO) else $error("primary count kept");
  a_cnt_b_clear: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    pwm_raw_in |=> cnt_b_reg == DB_ZERO) else $error("complement count kept");
  a_primary_pol: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    out_a_reg |-> $past(pwm_raw_in)) else $error("primary polarity");
  a_no_overlap: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !(out_a_reg && out_b_reg)) else $error("both outputs active");
  a_flag_holds: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    shutdown_active |=> flag_reg) else $error("flag not set in shutdown");
  a_auto_clear: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (flag_reg && !shutdown_active && restart_enable_bit) |=> !flag_reg)
    else $error("auto-restart did not clear flag");
  a_sticky_flag: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (flag_reg && !restart_enable_bit && !flag_clear_in && !wr_in) |=> flag_reg)
    else $error("flag cleared without software");
  a_quiet_flag: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    flag_reg |=> !out_a_reg && !out_b_reg) else $error("output during shutdown");
  a_deadband_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    $rose(out_a_reg) |-> $past(cnt_a_reg) >= $past(deadband_cycle_count))
    else $error("primary active before dead-band");
  a_deadband_b: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    $rose(out_b_reg) |-> $past(cnt_b_reg) >= $past(deadband_cycle_count))
    else $error("complement active before dead-band");
  a_compl_pol: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    out_b_reg |-> !$past(pwm_raw_in)) else $error("complement polarity");
endmodule
`default_nettype wire

// ===== logic/hbpwm_pkg.sv
// Constants and types for the half-bridge PWM output stage
//
// Overview of operation
// - Half-bridge drives two output pins together
// - Primary pin PWM, second pin its complement
// - Seven-bit dead-band count delays active edges
// - Dead-band beyond duty keeps output inactive
// - Auto-restart only when restart bit set
// - Shutdown flag holds while condition active
// - Condition gone, restart bit set: hardware clears flag, resumes
`default_nettype none
package hbpwm_pkg;
  localparam int DB_WIDTH = 7;
  localparam int DB_MSB   = 6;
  localparam int RST_BIT  = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [6:0] DB_ZERO    = 7'h00;
  localparam logic [6:0] DB_ONE     = 7'h01;

  typedef struct packed {
    logic pwm_primary;
    logic pwm_complement;
  } hbpwm_pins_s;
endpackage
`default_nettype wire
